// *** logic/bfs_supervisor.sv ***
// Design decisions made here: the register addresses and the Wishbone slave port.
`default_nettype none
module bfs_supervisor
   import bfs_pkg::*;
#(
   parameter int unsigned SS_CYCLES     = SS_CYC,
   parameter int unsigned PG_CYCLES     = PG_CYC,
   parameter int unsigned HICCUP_CYCLES = HICCUP_CYC
)
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic             wb_ack_o,
   output logic [31:0]      wb_dat_o,
   // System side
   input  wire logic        enable_i,
   input  wire logic        bias_supply_low_lockout_i,
   input  wire logic        input_supply_low_lockout_i,
   input  wire logic        over_temp_i,
   input  wire logic        forced_continuous_conduction_i,
   // Feedback comparators
   input  wire logic        undervoltage_protect_i,
   input  wire logic        overvoltage_protect_i,
   input  wire logic        early_overvoltage_window_i,
   input  wire logic        feedback_level_near_reference_i,
   input  wire logic        feedback_level_discharged_i,
   // Current comparators and loop
   input  wire logic        negative_current_limit_i,
   input  wire logic        zero_current_i,
   input  wire logic        loop_on_request_i,
   // Switch requests
   output logic             high_side_on_o,
   output logic             low_side_on_o,
   output logic             discharge_on_o,
   output logic             softstart_ref_node_reset_o,
   output logic             hiccup_o,
   output logic             softstart_ext_done_o,
   // Open-drain power good
   output logic             power_good_out_o,
   output logic             power_good_out_oe_n_o
);
   bfs_main_s          q;
   bfs_main_s          next_q;
   logic [N_TMR-1:0]   tmr_run;
   logic [N_TMR-1:0]   tmr_done;
   logic [TMR_W-1:0]   tmr_lim [N_TMR];
   logic               fault;
   logic               sw_en;
   logic               wb_req;

   // ---------------------------------------------
   // Decoding helpers
   // ---------------------------------------------
   function automatic logic is_active(input bfs_state_e s);
      is_active = (s == ST_SS) || (s == ST_RUN);
   endfunction

   function automatic logic is_timed(input bfs_state_e s);
      is_timed = (s == ST_SS) || (s == ST_HICCUP);
   endfunction

   // ---------------------------------------------
   // Timers
   // ---------------------------------------------
   // Phase timer serves soft-start and hiccup; they never abut, so it always restarts
   always_comb begin
      tmr_lim[TMR_PHASE] = (q.state == ST_HICCUP) ? TMR_W'(HICCUP_CYCLES)
                                                  : TMR_W'(SS_CYCLES);
      tmr_lim[TMR_PG]    = TMR_W'(PG_CYCLES);
      tmr_lim[TMR_UV]    = TMR_W'(UV_CYC);
      tmr_lim[TMR_WIN]   = TMR_W'(WIN_CYC);
      tmr_run[TMR_PHASE] = is_timed(q.state);
      tmr_run[TMR_PG]    = (q.state == ST_RUN) && q.ss_ext && !q.pg_fault;
      tmr_run[TMR_UV]    = (q.state == ST_RUN) && undervoltage_protect_i;
      tmr_run[TMR_WIN]   = (q.state == ST_RUN) && !q.pg_fault &&
                           (undervoltage_protect_i || overvoltage_protect_i);
   end

   genvar gi;
   generate
      for (gi = 0; gi < N_TMR; gi++) begin : g_tmr
         bfs_timer u_tmr (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .run_i   (tmr_run[gi]),
            .limit_i (tmr_lim[gi]),
            .done_o  (tmr_done[gi])
         );
      end
   endgenerate

   // ---------------------------------------------
   // Next-state logic
   // ---------------------------------------------
   always_comb begin
      next_q = q;
      fault  = !enable_i || bias_supply_low_lockout_i ||
               input_supply_low_lockout_i || over_temp_i;
      wb_req = wb_cyc_i && wb_stb_i && !q.wb_ack;

      // Power sequencing
      case (q.state)
         ST_OFF: begin
            // Waits for every condition at once, so arrival order is irrelevant
            if (!fault) begin
               next_q.state = ST_SS;
            end
         end
         ST_SS: begin
            if (fault) begin
               next_q.state = ST_DISCH;
            end else if (tmr_done[TMR_PHASE]) begin
               next_q.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (fault) begin
               next_q.state = ST_DISCH;
            end else if (tmr_done[TMR_UV]) begin
               next_q.state = ST_HICCUP;
            end
         end
         ST_HICCUP: begin
            if (fault) begin
               next_q.state = ST_DISCH;
            end else if (tmr_done[TMR_PHASE]) begin
               // Through OFF so the soft-start gets a clean, full count
               next_q.state = ST_OFF;
            end
         end
         ST_DISCH: begin
            if (feedback_level_discharged_i) begin
               next_q.state = ST_OFF;
            end
         end
         default: begin
            next_q.state = ST_OFF;
         end
      endcase

      // Per-start flags
      if (q.state == ST_OFF) begin
         next_q.ss_ext     = 1'b0;
         next_q.ov_latched = 1'b0;
      end else if (is_active(q.state)) begin
         if (feedback_level_near_reference_i) begin
            next_q.ss_ext = 1'b1;
         end
         if (overvoltage_protect_i) begin
            next_q.ov_latched = 1'b1;
         end
      end

      // Power-good latch; a set in the same cycle as a clear wins
      if (!enable_i || input_supply_low_lockout_i) begin
         next_q.pg_fault = 1'b0;
      end
      if (tmr_done[TMR_WIN]) begin
         next_q.pg_fault = 1'b1;
      end

      // Switching
      sw_en = is_active(next_q.state);
      if (!sw_en) begin
         next_q.sw      = SW_IDLE;
         next_q.ton_cnt = '0;
      end else begin
         case (q.sw)
            SW_IDLE: begin
               next_q.ton_cnt = '0;
               if (next_q.ov_latched) begin
                  next_q.sw = SW_LS;
               end else if (loop_on_request_i) begin
                  next_q.sw = SW_HS;
               end
            end
            SW_HS: begin
               // Same on-time in both conduction modes; DCM just idles longer
               if (q.ton_cnt + 8'h01 >= q.on_time) begin
                  next_q.sw      = SW_LS;
                  next_q.ton_cnt = '0;
               end else begin
                  next_q.ton_cnt = q.ton_cnt + 8'h01;
               end
            end
            SW_LS: begin
               next_q.ton_cnt = '0;
               if (negative_current_limit_i) begin
                  next_q.sw = SW_HS;
               end else if (!next_q.ov_latched && loop_on_request_i) begin
                  next_q.sw = SW_HS;
               end else if (!forced_continuous_conduction_i &&
                            !early_overvoltage_window_i &&
                            !next_q.ov_latched && zero_current_i) begin
                  next_q.sw = SW_IDLE;
               end
            end
            default: begin
               next_q.sw = SW_IDLE;
            end
         endcase
      end

      // Registered outputs
      next_q.hs      = (next_q.sw == SW_HS);
      next_q.ls      = (next_q.sw == SW_LS);
      next_q.disch   = (next_q.state == ST_DISCH);
      next_q.ss_rst  = !is_active(next_q.state);
      next_q.hiccup  = (next_q.state == ST_HICCUP);
      next_q.pg_good = (next_q.state == ST_RUN) && tmr_done[TMR_PG] &&
                       !next_q.pg_fault;

      // Wishbone: answer one cycle after the request, drop the next
      next_q.wb_ack = wb_req;
      next_q.wb_dat = '0;
      if (wb_req) begin
         if (wb_we_i) begin
            if (wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
               next_q.on_time = wb_dat_i[ONTIME_LSB +: 8];
            end
         end else begin
            case (wb_adr_i)
               ADR_CTRL: begin
                  next_q.wb_dat[ONTIME_LSB +: 8] = q.on_time;
               end
               ADR_STATUS: begin
                  next_q.wb_dat[ST_STATE_LSB +: 3] = q.state;
                  next_q.wb_dat[ST_SW_LSB +: 2]    = q.sw;
                  next_q.wb_dat[ST_PG_BIT]         = q.pg_good;
                  next_q.wb_dat[ST_PGF_BIT]        = q.pg_fault;
                  next_q.wb_dat[ST_OV_BIT]         = q.ov_latched;
                  next_q.wb_dat[ST_SSX_BIT]        = q.ss_ext;
                  next_q.wb_dat[ST_UVP_BIT]        = tmr_run[TMR_UV];
               end
               default: begin
                  next_q.wb_dat = '0;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q         <= '0;
         q.state   <= ST_OFF;
         q.sw      <= SW_IDLE;
         q.on_time <= ONTIME_RST;
         q.ss_rst  <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign wb_ack_o                   = q.wb_ack;
   assign wb_dat_o                   = q.wb_dat;
   assign high_side_on_o             = q.hs;
   assign low_side_on_o              = q.ls;
   assign discharge_on_o             = q.disch;
   assign softstart_ref_node_reset_o = q.ss_rst;
   assign hiccup_o                   = q.hiccup;
   assign softstart_ext_done_o       = q.ss_ext;
   // Open drain only ever pulls low
   assign power_good_out_o           = 1'b0;
   // Enable low means pulling low, the default from reset onward
   assign power_good_out_oe_n_o      = q.pg_good;
endmodule
`default_nettype wire

// *** logic/bfs_pkg.sv ***
`default_nettype none
package bfs_pkg;
   // ---------------------------------------------
   // Clock and timing
   // ---------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TMR_W         = 20;
   localparam int unsigned SS_TIME_NS    = 2_000_000;
   localparam int unsigned PG_DELAY_NS   = 1_060_000;
   localparam int unsigned HICCUP_NS     = 14_000_000;
   localparam int unsigned UV_DELAY_NS   = 68_000;
   localparam int unsigned WIN_DELAY_NS  = 2_000;
   // Least times round up to whole cycles
   localparam int unsigned SS_CYC     = (SS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PG_CYC     = (PG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HICCUP_CYC = (HICCUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned UV_CYC     = (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WIN_CYC    = (WIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------
   // Timer slots
   // ---------------------------------------------
   localparam int unsigned N_TMR     = 4;
   localparam int unsigned TMR_PHASE = 0;
   localparam int unsigned TMR_PG    = 1;
   localparam int unsigned TMR_UV    = 2;
   localparam int unsigned TMR_WIN   = 3;

   // ---------------------------------------------
   // Register map
   // ---------------------------------------------
   localparam logic [3:0] ADR_CTRL     = 4'h0;
   localparam logic [3:0] ADR_STATUS   = 4'h4;
   localparam logic [7:0] ONTIME_RST   = 8'h19;
   localparam int unsigned ONTIME_LSB  = 0;
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_SW_LSB    = 3;
   localparam int unsigned ST_PG_BIT    = 5;
   localparam int unsigned ST_PGF_BIT   = 6;
   localparam int unsigned ST_OV_BIT    = 7;
   localparam int unsigned ST_SSX_BIT   = 8;
   localparam int unsigned ST_UVP_BIT   = 9;

   // ---------------------------------------------
   // State types
   // ---------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF    = 3'b000,
      ST_SS     = 3'b001,
      ST_RUN    = 3'b010,
      ST_HICCUP = 3'b011,
      ST_DISCH  = 3'b100
   } bfs_state_e;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_HS   = 2'b01,
      SW_LS   = 2'b10
   } bfs_sw_e;

   typedef struct packed {
      bfs_state_e  state;
      bfs_sw_e     sw;
      logic [7:0]  ton_cnt;
      logic [7:0]  on_time;
      logic        ov_latched;
      logic        pg_fault;
      logic        ss_ext;
      logic        hs;
      logic        ls;
      logic        disch;
      logic        ss_rst;
      logic        hiccup;
      logic        pg_good;
      logic        wb_ack;
      logic [31:0] wb_dat;
   } bfs_main_s;
endpackage
`default_nettype wire

// *** logic/bfs_timer.sv ***
`default_nettype none
module bfs_timer
   import bfs_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Control
   input  wire logic             run_i,
   input  wire logic [TMR_W-1:0] limit_i,
   // Status
   output logic                  done_o
);
   typedef struct packed {
      logic [TMR_W-1:0] count;
      logic             done;
   } bfs_tmr_s;

   bfs_tmr_s q;
   bfs_tmr_s next_q;

   // ---------------------------------------------
   // Count while run is held; any drop clears it
   // ---------------------------------------------
   always_comb begin
      next_q = q;
      if (!run_i) begin
         next_q = '0;
      end else if (!q.done) begin
         if (q.count + TMR_W'(1) >= limit_i) begin
            next_q.done = 1'b1;
         end else begin
            next_q.count = q.count + TMR_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign done_o = q.done;
endmodule
`default_nettype wire

// *** bench/bfs_supervisor_checker.sv ***
`default_nettype none
module bfs_supervisor_checker
   import bfs_pkg::*;
#(
   parameter int unsigned PG_CYCLES = 10
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Conditions
   input wire logic enable_i,
   input wire logic bias_supply_low_lockout_i,
   input wire logic input_supply_low_lockout_i,
   input wire logic over_temp_i,
   input wire logic forced_continuous_conduction_i,
   input wire logic undervoltage_protect_i,
   input wire logic overvoltage_protect_i,
   input wire logic negative_current_limit_i,
   input wire logic zero_current_i,
   input wire logic loop_on_request_i,
   // Outputs watched
   input wire logic high_side_on_o,
   input wire logic low_side_on_o,
   input wire logic discharge_on_o,
   input wire logic softstart_ref_node_reset_o,
   input wire logic hiccup_o,
   input wire logic softstart_ext_done_o,
   input wire logic power_good_out_oe_n_o
);
   wire logic  fault = !enable_i || bias_supply_low_lockout_i || input_supply_low_lockout_i
                       || over_temp_i;
   wire logic  quiet = !negative_current_limit_i && !loop_on_request_i && !fault
                       && !undervoltage_protect_i;
   logic [15:0] win_cnt;
   logic [15:0] uv_cnt;

   // Run lengths; saturation is not needed within one bench run
   always_ff @(posedge clk_i) begin
      win_cnt <= (rst_i || !(power_good_out_oe_n_o && (undervoltage_protect_i
                 || overvoltage_protect_i))) ? 16'h0 : win_cnt + 16'h1;
      uv_cnt  <= (rst_i || !undervoltage_protect_i) ? 16'h0 : uv_cnt + 16'h1;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_NEG_LIM: assert property (low_side_on_o && negative_current_limit_i && !fault
      && !undervoltage_protect_i |=> high_side_on_o && !low_side_on_o)
      else $error("negative limit did not hand over to high side");
   AST_HS_THEN_LS: assert property ($fell(high_side_on_o) && !softstart_ref_node_reset_o
      && !hiccup_o |-> low_side_on_o) else $error("low side not back after on-time");
   AST_PG_DELAY: assert property ($rose(power_good_out_oe_n_o) |-> softstart_ext_done_o
      && $past(softstart_ext_done_o, PG_CYCLES)) else $error("power good rose too early");
   AST_WIN: assert property (win_cnt <= WIN_CYC + 3)
      else $error("power good not latched low on window fault");
   AST_PG_LOW_OFF: assert property (softstart_ref_node_reset_o ##1
      softstart_ref_node_reset_o |-> !power_good_out_oe_n_o)
      else $error("power good released while stopped");
   AST_UV_HICCUP: assert property ($rose(hiccup_o) |-> uv_cnt >= UV_CYC)
      else $error("hiccup without full undervoltage delay");
   AST_DISCH_SW: assert property (discharge_on_o |-> !high_side_on_o && !low_side_on_o)
      else $error("power switch on during discharge");
   AST_FAULT_OFF: assert property (fault [*2] |=> !high_side_on_o
      && !low_side_on_o && softstart_ref_node_reset_o) else $error("fault did not stop");
   AST_FORCED_CONTINUOUS_CONDUCTION: assert property (forced_continuous_conduction_i && low_side_on_o
      && zero_current_i && quiet |=> low_side_on_o) else $error("forced mode dropped low side");
   AST_HICCUP_SW: assert property (hiccup_o |-> !high_side_on_o && !low_side_on_o
      && !power_good_out_oe_n_o) else $error("activity during hiccup sleep");

   cover property ($rose(power_good_out_oe_n_o));
   cover property ($rose(hiccup_o));
   cover property ($rose(discharge_on_o));
endmodule

bind bfs_supervisor bfs_supervisor_checker #(.PG_CYCLES(PG_CYCLES)) u_chk (.*);
`default_nettype wire

// *** bench/bfs_host.sv ***
`default_nettype none
module bfs_host (
   // Clock
   input  wire logic clk_i,
   // Requests from the bench
   input  wire logic want_en_i,
   input  wire logic bias_low_i,
   // Open-drain line
   input  wire logic pg_drv_i,
   input  wire logic pg_oe_n_i,
   // To the block and the bench
   output logic      enable_o,
   output logic      pg_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en_q = 1'b0;

   // Enable only follows once bias is valid
   always @(posedge clk_i) en_q <= want_en_i && !bias_low_i;
   assign enable_o = en_q;
   // Pull-up sets the level once released
   assign pg_pin_o = pg_oe_n_i ? 1'b1 : pg_drv_i;
endmodule
`default_nettype wire

// *** bench/buck_fault_supervisor_bench.sv ***
`default_nettype none
module buck_fault_supervisor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import bfs_pkg::*;
   localparam int SSC = 20;
   localparam int PGC = 10;
   logic        clk_i, rst_i, cyc, stb, we, en_req, bias, vin_lo, ot, forced_continuous_conduction, uv, ov, early;
   logic        near, dis, nl, zc, loop, ack, hs, ls, dch, ssr, hic, ssd, pgo, oe_n, en, pg;
   logic [3:0]  adr, sel;
   logic [31:0] dat, dat_o, q;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          n;

   bfs_supervisor #(.SS_CYCLES(SSC), .PG_CYCLES(PGC), .HICCUP_CYCLES(30)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dat_o),
      .enable_i(en), .bias_supply_low_lockout_i(bias), .input_supply_low_lockout_i(vin_lo),
      .over_temp_i(ot), .forced_continuous_conduction_i(forced_continuous_conduction), .undervoltage_protect_i(uv),
      .overvoltage_protect_i(ov), .early_overvoltage_window_i(early),
      .feedback_level_near_reference_i(near), .feedback_level_discharged_i(dis),
      .negative_current_limit_i(nl), .zero_current_i(zc), .loop_on_request_i(loop),
      .high_side_on_o(hs), .low_side_on_o(ls), .discharge_on_o(dch),
      .softstart_ref_node_reset_o(ssr), .hiccup_o(hic), .softstart_ext_done_o(ssd),
      .power_good_out_o(pgo), .power_good_out_oe_n_o(oe_n));

   bfs_host u_host (.clk_i(clk_i), .want_en_i(en_req), .bias_low_i(bias), .pg_drv_i(pgo),
      .pg_oe_n_i(oe_n), .enable_o(en), .pg_pin_o(pg));

   // ----------------------------------
   // Helpers
   // ----------------------------------
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask

   // One classic cycle; released only at the edge that sees ack
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
      if (k >= 50) begin
         n_mismatch++;
         test_done;
      end
   endtask

   task automatic wait_state(input logic [2:0] st);
      int k;
      for (k = 0; k < 3000; k++) begin
         wb(1'b0, ADR_STATUS, 32'h0);
         if (q[2:0] === st) break;
      end
      if (q[2:0] !== st) begin
         n_mismatch++;
         test_done;
      end
   endtask

   task automatic pulse_loop;
      loop <= 1'b1;
      tick(1);
      loop <= 1'b0;
   endtask

   task automatic set_flt(input logic [3:0] f);
      en_req <= !f[0]; bias <= f[1]; vin_lo <= f[2]; ot <= f[3];
   endtask

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   initial begin
      repeat (90000) @(posedge clk_i);
      n_mismatch++;
      test_done;
   end

   // ----------------------------------
   // Sequence
   // ----------------------------------
   initial begin
      {cyc, stb, we, en_req, bias, vin_lo, ot, forced_continuous_conduction, uv, ov, early, near, dis, nl, zc, loop} = '0;
      adr = 4'h0; sel = 4'hf; dat = 32'h0; rst_i = 1'b1;
      tick(20);
      rst_i <= 1'b0;
      tick(1);
      wb(1'b0, ADR_CTRL, 32'h0); chk(q, {24'h0, ONTIME_RST});
      wb(1'b1, ADR_CTRL, 32'h4);
      sel <= 4'he;
      wb(1'b1, ADR_CTRL, 32'h9);
      sel <= 4'hf;
      wb(1'b0, ADR_CTRL, 32'h0); chk(q, 32'h4);
      wb(1'b1, ADR_STATUS, 32'h3ff);
      wb(1'b0, ADR_STATUS, 32'h0); chk(q, 32'h0);
      wb(1'b0, 4'h8, 32'h0); chk(q, 32'h0);
      near <= 1'b1; en_req <= 1'b1;
      tick(SSC / 2);
      wb(1'b0, ADR_STATUS, 32'h0); chk(q[2:0], ST_SS);
      chk(pg, 1'b0);
      wait_state(ST_RUN);
      chk(q[ST_SSX_BIT], 1'b1);
      chk(ssd, 1'b1);
      tick(PGC + 3); chk(pg, 1'b1);
      // Switching: on-time length, negative limit, modes
      pulse_loop;
      for (n = 0; n < 20 && hs !== 1'b1; n++) tick(1);
      for (n = 0; n < 20 && hs === 1'b1; n++) tick(1);
      chk(n, 4);
      chk(ls, 1'b1);
      nl <= 1'b1; tick(1); nl <= 1'b0; tick(1); chk(hs, 1'b1);
      tick(6); chk(ls, 1'b1);
      zc <= 1'b1; tick(3); chk(ls, 1'b0);
      zc <= 1'b0; forced_continuous_conduction <= 1'b1;
      pulse_loop;
      tick(8);
      zc <= 1'b1; tick(3); chk(ls, 1'b1);
      forced_continuous_conduction <= 1'b0; early <= 1'b1; tick(3); chk(ls, 1'b1);
      chk(pg, 1'b1);
      early <= 1'b0; zc <= 1'b0;
      // Undervoltage delay restart, hiccup, latched power good
      uv <= 1'b1; tick(1000); uv <= 1'b0; tick(2); chk(pg, 1'b0);
      uv <= 1'b1; tick(1000); uv <= 1'b0; tick(2); chk(hic, 1'b0);
      uv <= 1'b1;
      wait_state(ST_HICCUP);
      uv <= 1'b0;
      wait_state(ST_RUN);
      tick(PGC + 3); chk(pg, 1'b0);
      en_req <= 1'b0; tick(3); chk(dch, 1'b1);
      chk(hs | ls, 1'b0);
      dis <= 1'b1; tick(3); chk(dch, 1'b0);
      dis <= 1'b0; en_req <= 1'b1;
      wait_state(ST_RUN);
      tick(PGC + 3); chk(pg, 1'b1);
      // Overvoltage
      ov <= 1'b1; tick(3); ov <= 1'b0; chk(hs, 1'b0);
      chk(ls, 1'b1);
      nl <= 1'b1; tick(1); nl <= 1'b0; tick(1); chk(hs, 1'b1);
      uv <= 1'b1;
      wait_state(ST_HICCUP);
      uv <= 1'b0;
      wait_state(ST_RUN); chk(q[ST_OV_BIT], 1'b0);
      // Each discharge cause, then restart
      for (int i = 0; i < 4; i++) begin
         set_flt(4'h1 << i);
         tick(4); chk(dch, 1'b1);
         chk(ssr, 1'b1);
         dis <= 1'b1; tick(2);
         set_flt(4'h0);
         dis <= 1'b0;
         wait_state(ST_RUN);
      end
      test_done;
   end
endmodule
`default_nettype wire
